// ### rtl/odr_flash_ctrl.sv
// Serial flash slice: OTP program and lock, direct-read mode entry and exit.
`timescale 1ns/100ps
`default_nettype none
module odr_flash_ctrl #(
   parameter int POTP_CYCLES = 1000,
   parameter int DUMMY_CYCLES = 8,
   parameter bit BASIC_DR = 1'b0
) (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic chip_select_n_i,
   input wire logic serial_clock_i,
   input wire logic [3:0] serial_data_i,
   input wire logic reset_pin_n_i,
   input wire logic [1:0] protocol_i,
   input wire logic [2:0] nv_dr_mode_i,
   input wire logic otp_verify_fail_i,
   input wire logic [7:0] array_data_i,
   output logic [3:0] serial_data_o,
   output logic [3:0] serial_data_oe_o,
   output logic [odr_pkg::ADDR_BITS-1:0] array_addr_o,
   output logic direct_read_mode_o,
   output logic write_in_progress_o,
   output logic otp_writable_o
);
   import odr_pkg::*;

   localparam int TW = $clog2(POTP_CYCLES + 1);
   localparam logic [TW-1:0] POTP_LOAD = TW'(POTP_CYCLES);
   localparam logic [7:0] DUMMY_LAST = 8'(DUMMY_CYCLES - 1);

   // ==========================================================
   // Helper functions
   function automatic logic [3:0] lanes(input logic [1:0] proto);
      case (proto)
         PROTO_QUAD: lanes = 4'h4;
         PROTO_DUAL: lanes = 4'h2;
         default: lanes = 4'h1;
      endcase
   endfunction

   function automatic logic [23:0] shift_in(input logic [23:0] a, input logic [3:0] d,
                                             input logic [1:0] proto);
      case (proto)
         PROTO_QUAD: shift_in = {a[19:0], d};
         PROTO_DUAL: shift_in = {a[21:0], d[1:0]};
         default: shift_in = {a[22:0], d[0]};
      endcase
   endfunction

   function automatic logic [3:0] out_lanes(input logic [7:0] b, input logic [1:0] proto);
      case (proto)
         PROTO_QUAD: out_lanes = b[7:4];
         PROTO_DUAL: out_lanes = {2'b00, b[7:6]};
         default: out_lanes = {2'b00, b[7], 1'b0};
      endcase
   endfunction

   function automatic logic [3:0] oe_mask(input logic [1:0] proto);
      case (proto)
         PROTO_QUAD: oe_mask = 4'hF;
         PROTO_DUAL: oe_mask = 4'h3;
         default: oe_mask = 4'h2;
      endcase
   endfunction

   // Busy device refuses every command byte except status, flag and configuration reads and the flag clear
   function automatic odr_state_t cmd_route(input logic [7:0] code, input logic busy);
      case (code)
         CMD_READ_STATUS, CMD_READ_FLAGS, CMD_READ_VCFG: cmd_route = ST_OUT;
         CMD_FAST_READ, CMD_PGM_OTP: cmd_route = busy ? ST_SKIP : ST_ADDR;
         CMD_WRITE_VCFG: cmd_route = busy ? ST_SKIP : ST_IN;
         default: cmd_route = ST_SKIP;
      endcase
   endfunction

   // ==========================================================
   // Pin synchronisers and edge detection
   logic [12:0] meta_reg;
   logic [12:0] sync_reg;
   logic sck_prev_reg;
   logic cs_prev_reg;

   // Two flops per pin; the serial clock is oversampled, so it needs 4+ cycles per phase
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         meta_reg <= SYNC_RESET;
         sync_reg <= SYNC_RESET;
         sck_prev_reg <= 1'b0;
         cs_prev_reg <= 1'b1;
      end else begin
         meta_reg <= {nv_dr_mode_i, protocol_i, otp_verify_fail_i, reset_pin_n_i,
                      chip_select_n_i, serial_clock_i, serial_data_i};
         sync_reg <= meta_reg;
         sck_prev_reg <= sync_reg[4];
         cs_prev_reg <= sync_reg[5];
      end
   end

   logic [3:0] data_s;
   logic sck_s;
   logic cs_s;
   logic rst_pin_s;
   logic fail_s;
   logic [1:0] proto_s;
   logic [2:0] nv_s;
   assign data_s = sync_reg[3:0];
   assign sck_s = sync_reg[4];
   assign cs_s = sync_reg[5];
   assign rst_pin_s = sync_reg[6];
   assign fail_s = sync_reg[7];
   assign proto_s = sync_reg[9:8];
   assign nv_s = sync_reg[12:10];

   logic sck_rise_w;
   logic sck_fall_w;
   logic cs_fall_w;
   logic cs_rise_w;
   assign sck_rise_w = sck_s & ~sck_prev_reg & ~cs_s;
   assign sck_fall_w = ~sck_s & sck_prev_reg & ~cs_s;
   assign cs_fall_w = ~cs_s & cs_prev_reg;
   assign cs_rise_w = cs_s & ~cs_prev_reg;

   // ==========================================================
   // Frame decoder
   odr_state_t st_reg;
   logic [7:0] cmd_reg;
   logic cmd_ok_reg;
   logic [7:0] sh_reg;
   logic [3:0] cnt_reg;
   logic [5:0] abit_reg;
   logic [7:0] dummy_reg;
   logic [6:0] byte_idx_reg;
   logic [7:0] in_byte_reg;
   logic [23:0] addr_reg;
   logic [3:0] ocnt_reg;
   logic [7:0] out_sh_reg;
   logic dr_mode_reg;
   logic wip_reg;

   logic [3:0] lanes_w;
   logic [3:0] cnt_next_w;
   logic [23:0] sh_wide_w;
   logic [7:0] byte_in_w;
   logic byte_done_w;
   logic [5:0] abit_next_w;
   logic [3:0] ocnt_next_w;
   logic out_wrap_w;
   assign lanes_w = lanes(proto_s);
   assign cnt_next_w = cnt_reg + lanes_w;
   assign sh_wide_w = shift_in({16'h0000, sh_reg}, data_s, proto_s);
   assign byte_in_w = sh_wide_w[7:0];
   assign byte_done_w = (cnt_next_w == 4'h8);
   assign abit_next_w = abit_reg + {2'b00, lanes_w};
   assign ocnt_next_w = ocnt_reg + lanes_w;
   assign out_wrap_w = sck_fall_w && (st_reg == ST_OUT) && (ocnt_next_w == 4'h8);

   // One frame per select low; direct-read frames skip the command byte
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         st_reg <= ST_IDLE;
         cmd_reg <= 8'h00;
         cmd_ok_reg <= 1'b0;
         sh_reg <= 8'h00;
         cnt_reg <= 4'h0;
         abit_reg <= 6'h00;
         dummy_reg <= 8'h00;
         byte_idx_reg <= 7'h00;
         in_byte_reg <= 8'h00;
         addr_reg <= 24'h00_0000;
      end else if (cs_rise_w) begin
         st_reg <= ST_IDLE;
      end else if (cs_fall_w) begin
         st_reg <= dr_mode_reg ? ST_ADDR : ST_CMD;
         cmd_reg <= dr_mode_reg ? CMD_FAST_READ : 8'h00;
         cmd_ok_reg <= dr_mode_reg;
         sh_reg <= 8'h00;
         cnt_reg <= 4'h0;
         abit_reg <= 6'h00;
         dummy_reg <= 8'h00;
         byte_idx_reg <= 7'h00;
      end else if (sck_rise_w) begin
         case (st_reg)
            ST_CMD: begin
               sh_reg <= byte_in_w;
               cnt_reg <= byte_done_w ? 4'h0 : cnt_next_w;
               if (byte_done_w) begin
                  cmd_reg <= byte_in_w;
                  cmd_ok_reg <= 1'b1;
                  st_reg <= cmd_route(byte_in_w, wip_reg);
               end
            end
            ST_ADDR: begin
               addr_reg <= shift_in(addr_reg, data_s, proto_s);
               abit_reg <= abit_next_w;
               if (abit_next_w == 6'(ADDR_BITS)) begin
                  st_reg <= (cmd_reg == CMD_FAST_READ) ? ST_DUMMY : ST_IN;
               end
            end
            ST_DUMMY: begin
               dummy_reg <= dummy_reg + 8'h01;
               if (dummy_reg == DUMMY_LAST) begin
                  st_reg <= ST_OUT;
               end
            end
            ST_IN: begin
               sh_reg <= byte_in_w;
               cnt_reg <= byte_done_w ? 4'h0 : cnt_next_w;
               if (byte_done_w) begin
                  if (byte_idx_reg == 7'h00) begin
                     in_byte_reg <= byte_in_w;
                  end
                  if (byte_idx_reg != 7'h7F) begin
                     byte_idx_reg <= byte_idx_reg + 7'h01;
                  end
               end
            end
            default: begin
            end
         endcase
      end else if (out_wrap_w && cmd_reg == CMD_FAST_READ) begin
         addr_reg <= addr_reg + 24'h00_0001;
      end
   end

   // ==========================================================
   // Read data path
   logic [7:0] vcfg_reg;
   logic wel_reg;
   logic pfail_reg;
   logic prot_reg;
   logic [7:0] out_src_w;
   logic [7:0] out_byte_w;

   // Source byte chosen by the command in flight
   always_comb begin
      out_src_w = 8'h00;
      case (cmd_reg)
         CMD_READ_STATUS: begin
            out_src_w[SR_WIP_BIT] = wip_reg;
            out_src_w[SR_WEL_BIT] = wel_reg;
         end
         CMD_READ_FLAGS: begin
            out_src_w[FSR_READY_BIT] = ~wip_reg;
            out_src_w[FSR_PFAIL_BIT] = pfail_reg;
            out_src_w[FSR_PROT_BIT] = prot_reg;
         end
         CMD_READ_VCFG: out_src_w = vcfg_reg;
         default: out_src_w = array_data_i;
      endcase
   end
   assign out_byte_w = (ocnt_reg == 4'h0) ? out_src_w : out_sh_reg;

   // Drive on falling serial clock so the host samples a settled line on the rise
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         serial_data_o <= 4'h0;
         serial_data_oe_o <= 4'h0;
         out_sh_reg <= 8'h00;
         ocnt_reg <= 4'h0;
      end else if (st_reg != ST_OUT) begin
         serial_data_oe_o <= 4'h0;
         ocnt_reg <= 4'h0;
      end else if (sck_fall_w) begin
         serial_data_o <= out_lanes(out_byte_w, proto_s);
         serial_data_oe_o <= oe_mask(proto_s);
         out_sh_reg <= out_byte_w << lanes_w;
         ocnt_reg <= out_wrap_w ? 4'h0 : ocnt_next_w;
      end
   end

   // ==========================================================
   // Direct-read mode and volatile configuration
   logic [1:0] boot_cnt_reg;
   logic nv_load_w;
   logic confirm_w;
   logic vcfg_write_w;
   // Straps are read only once they have crossed the synchroniser
   assign nv_load_w = (boot_cnt_reg == BOOT_LOAD) || (!rst_pin_s && cs_s);
   // Only line 0 in the first dummy clock carries the confirmation
   assign confirm_w = sck_rise_w && (st_reg == ST_DUMMY) && (dummy_reg == 8'h00);
   assign vcfg_write_w = cs_rise_w && cmd_ok_reg && (cmd_reg == CMD_WRITE_VCFG) &&
                         (st_reg == ST_IN) && (byte_idx_reg != 7'h00) && (cnt_reg == 4'h0);

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         boot_cnt_reg <= 2'h0;
         dr_mode_reg <= 1'b0;
         vcfg_reg <= VCFG_RESET;
      end else begin
         if (boot_cnt_reg != BOOT_DONE) begin
            boot_cnt_reg <= boot_cnt_reg + 2'h1;
         end
         if (nv_load_w) begin
            dr_mode_reg <= (nv_s != NV_DR_OFF);
            vcfg_reg <= VCFG_RESET;
         end else if (confirm_w) begin
            if (dr_mode_reg && data_s[0]) begin
               dr_mode_reg <= 1'b0;
               vcfg_reg[VCFG_DR_BIT] <= 1'b1;
            end else if (!dr_mode_reg && !data_s[0] &&
                         (BASIC_DR || !vcfg_reg[VCFG_DR_BIT])) begin
               dr_mode_reg <= 1'b1;
            end
         end else if (vcfg_write_w) begin
            vcfg_reg <= in_byte_reg;
         end
      end
   end

   // ==========================================================
   // Write latch, busy, flags and OTP program engine
   logic [7:0] otp_reg [0:OTP_BYTES-1];
   logic [7:0] pend_reg [0:OTP_BYTES-1];
   logic [TW-1:0] timer_reg;
   logic pgm_req_w;
   logic pgm_start_w;
   logic pgm_locked_w;
   logic done_w;
   logic clr_flags_w;
   logic wren_w;
   logic wrdi_w;
   logic [7:0] pend_idx_w;
   logic pend_wr_w;

   // Only a full-byte frame closed by deselect counts
   assign pgm_req_w = cs_rise_w && cmd_ok_reg && (cmd_reg == CMD_PGM_OTP) && (st_reg == ST_IN) &&
                      (byte_idx_reg != 7'h00) && (cnt_reg == 4'h0) && !wip_reg;
   assign pgm_start_w = pgm_req_w && wel_reg && otp_reg[OTP_LOCK_IDX][LOCK_BIT];
   assign pgm_locked_w = pgm_req_w && wel_reg && !otp_reg[OTP_LOCK_IDX][LOCK_BIT];
   assign done_w = wip_reg && (timer_reg == '0);
   assign wren_w = cs_rise_w && cmd_ok_reg && (cmd_reg == CMD_WRITE_ENABLE) && !wip_reg;
   assign wrdi_w = cs_rise_w && cmd_ok_reg && (cmd_reg == CMD_WRITE_DISABLE) && !wip_reg;
   assign clr_flags_w = cs_rise_w && cmd_ok_reg && (cmd_reg == CMD_CLEAR_FLAGS);
   assign pend_idx_w = {1'b0, addr_reg[6:0]} + {1'b0, byte_idx_reg};
   // Bytes past the top of the area are dropped, no wraparound
   assign pend_wr_w = sck_rise_w && (st_reg == ST_IN) && byte_done_w &&
                      (cmd_reg == CMD_PGM_OTP) && (pend_idx_w < 8'(OTP_BYTES));

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         wel_reg <= 1'b0;
         wip_reg <= 1'b0;
         timer_reg <= '0;
         pfail_reg <= 1'b0;
         prot_reg <= 1'b0;
      end else begin
         if (!rst_pin_s && cs_s) begin
            wel_reg <= 1'b0;
         end else if (done_w) begin
            wel_reg <= 1'b0;
         end else if (wren_w) begin
            wel_reg <= 1'b1;
         end else if (wrdi_w) begin
            wel_reg <= 1'b0;
         end
         if (pgm_start_w) begin
            wip_reg <= 1'b1;
            timer_reg <= POTP_LOAD;
         end else if (done_w) begin
            wip_reg <= 1'b0;
         end else if (wip_reg) begin
            timer_reg <= timer_reg - TW'(1);
         end
         // A flag set in the same cycle as a clear survives
         pfail_reg <= (pfail_reg & ~clr_flags_w) | (done_w & fail_s) | pgm_locked_w;
         prot_reg <= (prot_reg & ~clr_flags_w) | pgm_locked_w;
      end
   end

   // Flash cells only go from one to zero, so only reset_i can reopen the lock
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         for (int i = 0; i < OTP_BYTES; i++) begin
            otp_reg[i] <= OTP_ERASED;
            pend_reg[i] <= OTP_ERASED;
         end
      end else begin
         for (int i = 0; i < OTP_BYTES; i++) begin
            if (cs_fall_w && !wip_reg) begin
               pend_reg[i] <= OTP_ERASED;
            end else if (pend_wr_w && pend_idx_w == 8'(i)) begin
               pend_reg[i] <= byte_in_w;
            end
            if (done_w && !fail_s) begin
               otp_reg[i] <= otp_reg[i] & pend_reg[i];
            end
         end
      end
   end

   assign array_addr_o = addr_reg;
   assign direct_read_mode_o = dr_mode_reg;
   assign write_in_progress_o = wip_reg;
   assign otp_writable_o = otp_reg[OTP_LOCK_IDX][LOCK_BIT];

   // ==========================================================
   // Assertions
   a_wel_after_done: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      $fell(wip_reg) |-> !wel_reg) else $error("write latch still set after OTP program");
   a_wip_holds: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      $rose(wip_reg) |-> wip_reg [*8]) else $error("busy bit dropped too early");
   a_timeout_fail: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      done_w && fail_s |=> pfail_reg && !wel_reg && !wip_reg) else $error("timeout not flagged");
   a_start_on_deselect: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      $rose(wip_reg) |-> $past(cs_rise_w) && $past(wel_reg)) else $error("program without deselect");
   a_lock_sticky: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      !otp_reg[OTP_LOCK_IDX][LOCK_BIT] |=> !otp_reg[OTP_LOCK_IDX][LOCK_BIT])
      else $error("lock bit returned to one");
   a_locked_ignored: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      pgm_locked_w |=> prot_reg && pfail_reg && wel_reg && !wip_reg)
      else $error("locked program not refused properly");
   a_mode_enter: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      confirm_w && !nv_load_w && !dr_mode_reg && !data_s[0] && !vcfg_reg[VCFG_DR_BIT]
      |=> dr_mode_reg) else $error("direct-read mode not entered");
   a_frame_addr_first: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      cs_fall_w && dr_mode_reg |=> st_reg == ST_ADDR && cmd_reg == CMD_FAST_READ)
      else $error("direct-read frame expected a command");
   a_mode_exit: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      confirm_w && !nv_load_w && dr_mode_reg && data_s[0]
      |=> !dr_mode_reg && vcfg_reg[VCFG_DR_BIT]) else $error("direct-read mode not left");
   a_reset_pin_reload: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      !rst_pin_s && cs_s |=> dr_mode_reg == ($past(nv_s) != NV_DR_OFF))
      else $error("reset pin did not reload boot mode");
   a_exit_keeps_busy: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      confirm_w && dr_mode_reg && data_s[0] && !done_w && !pgm_start_w |=> $stable(wip_reg))
      else $error("mode exit disturbed program");
endmodule
`default_nettype wire

// ### rtl/odr_pkg.sv
// Constants and types shared by the OTP lock and direct-read flash block.
package odr_pkg;
   localparam int ADDR_BITS = 24;
   localparam int OTP_BYTES = 65;
   localparam logic [6:0] OTP_LOCK_IDX = 7'h40;
   localparam int LOCK_BIT = 0;
   localparam logic [7:0] OTP_ERASED = 8'hFF;
   localparam logic [7:0] VCFG_RESET = 8'hFF;
   localparam int VCFG_DR_BIT = 3;
   localparam logic [2:0] NV_DR_OFF = 3'h7;
   localparam int SR_WIP_BIT = 0;
   localparam int SR_WEL_BIT = 1;
   localparam int FSR_PROT_BIT = 1;
   localparam int FSR_PFAIL_BIT = 4;
   localparam int FSR_READY_BIT = 7;
   localparam logic [1:0] PROTO_EXT = 2'h0;
   localparam logic [1:0] PROTO_DUAL = 2'h1;
   localparam logic [1:0] PROTO_QUAD = 2'h2;
   localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] CMD_READ_STATUS = 8'h05;
   localparam logic [7:0] CMD_READ_FLAGS = 8'h70;
   localparam logic [7:0] CMD_CLEAR_FLAGS = 8'h50;
   localparam logic [7:0] CMD_WRITE_VCFG = 8'h81;
   localparam logic [7:0] CMD_READ_VCFG = 8'h85;
   localparam logic [7:0] CMD_FAST_READ = 8'h0B;
   localparam logic [7:0] CMD_PGM_OTP = 8'h42;
   // Sync bundle: [3:0] data, 4 clock, 5 select, 6 reset pin, 7 fail, [9:8] proto, [12:10] nv
   localparam logic [12:0] SYNC_RESET = 13'h1C60;
   localparam logic [1:0] BOOT_LOAD = 2'h2;
   localparam logic [1:0] BOOT_DONE = 2'h3;
   typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_ADDR, ST_DUMMY, ST_IN, ST_OUT, ST_SKIP} odr_state_t;
endpackage

// ### tb/odr_host_model.sv
// Behavioural serial host that frames commands towards the flash slice.
`timescale 1ns/100ps
`default_nettype none
module odr_host_model (
   input wire logic sys_clk_i,
   input wire logic [3:0] sd_i,
   output var logic cs_n_o,
   output var logic sclk_o,
   output var logic [3:0] sd_o
);
   // ==========================================
   // Idle levels: serial clock stands still low outside frames
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      sd_o = 4'h0;
   end
   // Half of a 32 ns serial clock, launched just after a system edge
   task automatic half();
      repeat (4) @(posedge sys_clk_i);
      #1;
   endtask
   // Select high gap of at least four system clocks comes before each frame
   task automatic start();
      half();
      cs_n_o = 1'b0;
      half();
   endtask
   // Released lines flip, so a stale value can never pass for a driven one
   task automatic stop();
      half();
      cs_n_o = 1'b1;
      sd_o = ~sd_o;
   endtask
   // Shift clocks*lanes bits MSB first, reading the answer at each rising edge
   task automatic xfer(input logic [31:0] v, input int clocks, input int lanes,
         output logic [31:0] rd);
      logic [3:0] m;
      logic [31:0] c;
      m = 4'((1 << lanes) - 1);
      rd = '0;
      for (int i = 0; i < clocks; i++) begin
         c = v >> ((clocks - 1 - i) * lanes);
         sd_o = (c[3:0] & m) | (~sd_o & ~m);
         half();
         sclk_o = 1'b1;
         rd = (rd << lanes) | ((lanes == 1) ? 32'(sd_i[1]) : 32'(sd_i & m));
         half();
         sclk_o = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// ### tb/otp_lock_and_direct_read_mode_bench.sv
// Self-checking bench: OTP program and lock, direct-read entry, exit and reload.
`timescale 1ns/100ps
`default_nettype none
module otp_lock_and_direct_read_mode_bench;
   import odr_pkg::*;
   // ==========================================
   // Short program time keeps the run brief; expectations derive from it
   localparam int POTP = 20;
   localparam int DUMMY = 4;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic rst_pin_n = 1'b1;
   logic [1:0] proto = PROTO_EXT;
   logic [2:0] nv_mode = NV_DR_OFF;
   logic fail = 1'b0;
   logic cs_n, sclk;
   logic [3:0] sd_in, sd_out, sd_oe;
   logic [ADDR_BITS-1:0] addr;
   logic [7:0] arr_data;
   logic dr_mode, wip, otp_wr;
   logic [31:0] rd;
   int ln = 1;
   int bad_count = 0;
   int checked = 0;
   always #2 sys_clk = ~sys_clk;
   // Array content follows the address so each read proves where it came from
   assign arr_data = addr[7:0] ^ 8'hA5;
   odr_flash_ctrl #(.POTP_CYCLES(POTP), .DUMMY_CYCLES(DUMMY), .BASIC_DR(1'b0)) dut_u (
      .sys_clk_i(sys_clk), .reset_i(reset), .chip_select_n_i(cs_n),
      .serial_clock_i(sclk), .serial_data_i(sd_in), .reset_pin_n_i(rst_pin_n),
      .protocol_i(proto), .nv_dr_mode_i(nv_mode), .otp_verify_fail_i(fail),
      .array_data_i(arr_data), .serial_data_o(sd_out), .serial_data_oe_o(sd_oe),
      .array_addr_o(addr), .direct_read_mode_o(dr_mode),
      .write_in_progress_o(wip), .otp_writable_o(otp_wr));
   // Lanes the flash is not driving read inverted, so a stale bit never passes for data
   odr_host_model host_u (.sys_clk_i(sys_clk), .sd_i((sd_out & sd_oe) | (~sd_out & ~sd_oe)),
      .cs_n_o(cs_n), .sclk_o(sclk), .sd_o(sd_in));
   // ==========================================
   // Comparison, report and shared bus tasks
   task automatic give_verdict();
      $display("checked=%0d bad_count=%0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk_byte({7'h00, got}, {7'h00, exp});
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic send(input logic [31:0] v, input int bits);
      host_u.xfer(v, bits / ln, ln, rd);
   endtask
   // Command byte plus an optional byte out or in; result lands in rd
   task automatic frame(input logic [7:0] c, input logic [7:0] d, input int nb);
      host_u.start();
      send(c, 8);
      if (nb > 0) begin
         send(d, nb);
      end
      host_u.stop();
   endtask
   task automatic otp_prog(input logic [23:0] a, input logic [7:0] d);
      frame(CMD_WRITE_ENABLE, 8'h00, 0);
      host_u.start();
      send(CMD_PGM_OTP, 8);
      send(a, 24);
      send(d, 8);
      host_u.stop();
   endtask
   // Busy length in system clocks; a stuck busy ends the run as a mismatch
   task automatic busy_len(output int n);
      n = 0;
      for (int i = 0; i < 20 && wip !== 1'b1; i++) begin
         idle(1);
      end
      while (wip === 1'b1 && n < 200) begin
         idle(1);
         n++;
      end
      if (n >= 200) begin
         bad_count++;
         give_verdict();
      end
   endtask
   // Address, confirm bit in first dummy with upper lines high, then two bytes
   task automatic dr_tail(input logic [23:0] a, input logic cb);
      send(a, 24);
      host_u.xfer({28'h000_0007, cb}, 1, 4, rd);
      host_u.xfer(32'h0000_0000, DUMMY - 1, 1, rd);
      send(32'h0000_0000, 16);
      chk_byte({4'h0, sd_oe}, (ln == 4) ? 8'h0F : 8'(ln + 1));
      chk_byte(rd[15:8], a[7:0] ^ 8'hA5);
      chk_byte(rd[7:0], (a[7:0] + 8'h01) ^ 8'hA5);
      host_u.stop();
   endtask
   task automatic exit_seq(input int n);
      host_u.start();
      host_u.xfer(32'hFFFF_FFFF, n, 1, rd);
      host_u.stop();
      idle(8);
   endtask
   // ==========================================
   // Scenarios
   task automatic t_otp_fail();
      int n;
      fail = 1'b1;
      otp_prog(24'h00_0003, 8'h3C);
      busy_len(n);
      chk_byte(8'(n), 8'(POTP + 1));
      frame(CMD_READ_STATUS, 8'h00, 8);
      chk_byte(rd[7:0] & 8'h03, 8'h00);
      frame(CMD_READ_FLAGS, 8'h00, 8);
      chk_byte(rd[7:0] & 8'h10, 8'h10);
      frame(CMD_CLEAR_FLAGS, 8'h00, 0);
      fail = 1'b0;
      $display("done otp_fail");
   endtask
   // A frame cut short inside the data byte must not start a program
   task automatic t_cut();
      frame(CMD_WRITE_ENABLE, 8'h00, 0);
      host_u.start();
      send(CMD_PGM_OTP, 8);
      send(24'h00_0001, 24);
      send(32'h0000_0005, 4);
      host_u.stop();
      idle(20);
      chk_bit(wip, 1'b0);
      frame(CMD_READ_STATUS, 8'h00, 8);
      chk_byte(rd[7:0] & 8'h03, 8'h02);
      frame(CMD_READ_FLAGS, 8'h00, 8);
      chk_byte(rd[7:0] & 8'h12, 8'h00);
      frame(CMD_WRITE_DISABLE, 8'h00, 0);
      frame(CMD_READ_STATUS, 8'h00, 8);
      chk_byte(rd[7:0] & 8'h03, 8'h00);
      $display("done cut");
   endtask
   task automatic t_lock();
      int n;
      chk_bit(otp_wr, 1'b1);
      otp_prog({17'h0_0000, OTP_LOCK_IDX}, 8'hFE);
      busy_len(n);
      chk_bit(otp_wr, 1'b0);
      otp_prog({17'h0_0000, OTP_LOCK_IDX}, 8'hFF);
      idle(20);
      chk_bit(wip, 1'b0);
      chk_bit(otp_wr, 1'b0);
      frame(CMD_READ_STATUS, 8'h00, 8);
      chk_byte(rd[7:0] & 8'h03, 8'h02);
      frame(CMD_READ_FLAGS, 8'h00, 8);
      chk_byte(rd[7:0] & 8'h12, 8'h12);
      $display("done lock");
   endtask
   task automatic t_dr(input logic [1:0] pr, input int lanes, input int nexit);
      proto = pr;
      ln = lanes;
      idle(8);
      frame(CMD_WRITE_VCFG, 8'hF7, 8);
      host_u.start();
      send(CMD_FAST_READ, 8);
      dr_tail(24'h00_1234, 1'b0);
      idle(8);
      chk_bit(dr_mode, 1'b1);
      chk_byte({4'h0, sd_oe}, 8'h00);
      host_u.start();
      dr_tail(24'h00_0456, 1'b0);
      chk_bit(dr_mode, 1'b1);
      exit_seq(nexit);
      chk_bit(dr_mode, 1'b0);
      chk_bit(otp_wr, 1'b0);
      frame(CMD_READ_FLAGS, 8'h00, 8);
      chk_byte(rd[7:0] & 8'h12, 8'h12);
      frame(CMD_READ_VCFG, 8'h00, 8);
      chk_byte(rd[7:0], VCFG_RESET);
      $display("done direct read %0d lanes", lanes);
   endtask
   // Reset pin pulsed while deselected reloads the boot straps
   task automatic t_boot();
      proto = PROTO_EXT;
      ln = 1;
      nv_mode = 3'h0;
      idle(4);
      rst_pin_n = 1'b0;
      idle(16);
      rst_pin_n = 1'b1;
      idle(8);
      chk_bit(dr_mode, 1'b1);
      host_u.start();
      dr_tail(24'h00_0789, 1'b0);
      exit_seq(25);
      chk_bit(dr_mode, 1'b0);
      $display("done boot");
   endtask
   initial begin
      idle(8);
      reset = 1'b0;
      idle(6);
      chk_bit(dr_mode, 1'b0);
      chk_bit(wip, 1'b0);
      t_otp_fail();
      t_cut();
      t_lock();
      t_dr(PROTO_EXT, 1, 25);
      t_dr(PROTO_DUAL, 2, 13);
      t_dr(PROTO_QUAD, 4, 7);
      t_boot();
      give_verdict();
   end
endmodule
`default_nettype wire
